// ==== rtl/sac_pkg.sv ====
// Purpose: Shared constants for the converter control block
// Assumes: 8-bit register port, clock is the high-frequency clock
// Notes: Conversion times are counted in clock periods
package sac_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] SAC_OFS_CTRL_ONE = 8'h1C;
    localparam logic [7:0] SAC_OFS_CTRL_TWO = 8'h1D;
    localparam logic [7:0] SAC_OFS_RES_LOW = 8'h1E;
    localparam logic [7:0] SAC_OFS_RES_HIGH = 8'h1F;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int SAC_START_BIT = 7;
    localparam int SAC_MODE_LSB = 5;
    localparam int SAC_AIN_DIS_BIT = 4;
    localparam int SAC_LADDER_BIT = 5;
    localparam int SAC_EOC_BIT = 5;
    localparam int SAC_BUSY_BIT = 4;
    localparam logic [7:0] SAC_CTRL_ONE_RST = 8'h10;
    localparam logic [5:0] SAC_CTRL_TWO_RST = 6'h00;
    localparam logic [7:0] SAC_RES_RST = 8'h00;
    localparam logic [9:0] SAC_SAR_FIRST = 10'h200;
    localparam logic [10:0] SAC_CMP_STEPS = 11'h00A;

    typedef enum logic [1:0] {
        SAC_MODE_OFF = 2'b00,
        SAC_MODE_SOFT = 2'b01,
        SAC_MODE_RSVD = 2'b10,
        SAC_MODE_REPEAT = 2'b11
    } sac_mode_t;

    // ----------------------------------------
    // Conversion times in clock periods
    // ----------------------------------------
    localparam logic [10:0] SAC_T39 = 11'd39;
    localparam logic [10:0] SAC_T78 = 11'd78;
    localparam logic [10:0] SAC_T156 = 11'd156;
    localparam logic [10:0] SAC_T312 = 11'd312;
    localparam logic [10:0] SAC_T624 = 11'd624;
    localparam logic [10:0] SAC_T1248 = 11'd1248;

    // Reserved codes fall back to the shortest time
    function automatic logic [10:0] sac_conv_cycles(input logic [2:0] code);
        case (code)
            3'h2: sac_conv_cycles = SAC_T78;
            3'h3: sac_conv_cycles = SAC_T156;
            3'h4: sac_conv_cycles = SAC_T312;
            3'h5: sac_conv_cycles = SAC_T624;
            3'h6: sac_conv_cycles = SAC_T1248;
            default: sac_conv_cycles = SAC_T39;
        endcase
    endfunction
endpackage

// ==== rtl/sac_sar_if.sv ====
// Purpose: Carrier between control logic and approximation core
// Assumes: One clock domain
// Notes: done is a one-cycle pulse
`timescale 1ns/10ps
interface sac_sar_if;
    logic start;
    logic abort;
    logic [10:0] cycles;
    logic cmp;
    logic busy;
    logic done;
    logic sampling;
    logic [9:0] trial;
    logic [9:0] result;
    modport ctrl (output start, abort, cycles, cmp, input busy, done, sampling, trial, result);
    modport core (input start, abort, cycles, cmp, output busy, done, sampling, trial, result);
endinterface

// ==== rtl/sac_sar_core.sv ====
// Purpose: Successive approximation timing and bit decisions
// Assumes: Comparator high means input at or above the trial code
// Notes: Sampling fills the time before the last ten cycles
`timescale 1ns/10ps
module sac_sar_core
    import sac_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    sac_sar_if.core sar
);
    logic [10:0] cnt_q, cnt_d;
    logic [9:0] sar_q, sar_d;
    logic [9:0] res_q, res_d;
    logic busy_q, busy_d;
    logic done_q, done_d;
    logic [3:0] idx;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        cnt_d = cnt_q;
        sar_d = sar_q;
        res_d = res_q;
        busy_d = busy_q;
        done_d = 1'b0;
        idx = 4'(cnt_q - 11'd1);
        if (sar.abort)
        begin
            busy_d = 1'b0;
        end
        else if (sar.start)
        begin
            cnt_d = sar.cycles;
            sar_d = SAC_SAR_FIRST;
            busy_d = 1'b1;
        end
        else if (busy_q)
        begin
            cnt_d = cnt_q - 11'd1;
            if (cnt_q <= SAC_CMP_STEPS)
            begin
                if (!sar.cmp)
                    sar_d[idx] = 1'b0;
                if (idx != 4'h0)
                    sar_d[idx - 4'h1] = 1'b1;
            end
            if (cnt_q == 11'd1)
            begin
                busy_d = 1'b0;
                done_d = 1'b1;
                res_d = sar_d;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_q <= 11'h000;
            sar_q <= 10'h000;
            res_q <= 10'h000;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            sar_q <= sar_d;
            res_q <= res_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign sar.busy = busy_q;
    assign sar.done = done_q;
    // Next trial goes out, so the registered DAC code matches the bit under test
    assign sar.trial = sar_d;
    assign sar.result = res_q;
    assign sar.sampling = busy_q && (cnt_q > SAC_CMP_STEPS);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    first_trial_a: assert property (sar.start && !sar.abort |=> sar_q == SAC_SAR_FIRST)
        else $error("first trial code wrong");
    expiry_done_a: assert property (busy_q && cnt_q == 11'd1 && !sar.abort && !sar.start
        |=> done_q && !busy_q)
        else $error("count expiry without done");
endmodule

// ==== rtl/sac_adc_ctrl.sv ====
// Purpose: Register and sequencing logic of a 10-bit converter
// Assumes: Standby level is high in stop, slow and sleep modes
// Notes: Reads return data in the cycle after the read strobe
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
module sac_adc_ctrl
    import sac_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic standby_i,
    input wire logic cmp_i,
    output logic [7:0] rdata_o,
    output logic [9:0] dac_code_o,
    output logic [3:0] channel_o,
    output logic sample_o,
    output logic ladder_on_o,
    output logic ain_disable_o,
    output logic conv_done_irq_o
);
    sac_sar_if sar ();

    logic start_q, start_d;
    logic [1:0] mode_q, mode_d;
    logic ain_dis_q, ain_dis_d;
    logic [3:0] chan_q, chan_d;
    logic [5:0] ctl2_q, ctl2_d;
    logic [7:0] res_hi_q, res_hi_d;
    logic [1:0] res_lo_q, res_lo_d;
    logic eoc_q, eoc_d;
    logic busy_q, busy_d;
    logic irq_q, irq_d;
    logic [7:0] rdata_q, rdata_d;
    logic [9:0] dac_q, dac_d;
    logic sample_q, sample_d;
    logic ladder_q, ladder_d;
    logic wr_one, wr_two, rd_high;
    logic go, abort, done;
    logic [1:0] mode_w;

    // ----------------------------------------
    // Register access decode
    // ----------------------------------------
    always_comb
    begin
        wr_one = wr_i && !standby_i && (addr_i == SAC_OFS_CTRL_ONE);
        wr_two = wr_i && !standby_i && (addr_i == SAC_OFS_CTRL_TWO);
        rd_high = rd_i && (addr_i == SAC_OFS_RES_HIGH);
        mode_w = wdata_i[SAC_MODE_LSB +: 2];
    end

    // ----------------------------------------
    // Conversion sequencing
    // ----------------------------------------
    always_comb
    begin
        done = sar.done && !standby_i;
        abort = standby_i || (wr_one && mode_w == SAC_MODE_OFF && busy_q);
        // only modes 01 and 11 run
        go = !abort && (mode_q == SAC_MODE_SOFT || mode_q == SAC_MODE_REPEAT)
            && ((start_q && !busy_q) || (done && mode_q == SAC_MODE_REPEAT));
        sar.start = go;
        sar.abort = abort;
        sar.cycles = sac_conv_cycles(ctl2_q[3:1]);
        sar.cmp = cmp_i;
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always_comb
    begin
        start_d = start_q;
        mode_d = mode_q;
        ain_dis_d = ain_dis_q;
        chan_d = chan_q;
        ctl2_d = ctl2_q;
        if (go && start_q)
            start_d = 1'b0;
        if (wr_one)
        begin
            start_d = wdata_i[SAC_START_BIT];
            mode_d = mode_w;
            ain_dis_d = wdata_i[SAC_AIN_DIS_BIT];
            chan_d = wdata_i[3:0];
        end
        if (wr_two)
            ctl2_d = wdata_i[5:0];
        if (standby_i)
        begin
            start_d = SAC_CTRL_ONE_RST[SAC_START_BIT];
            mode_d = SAC_CTRL_ONE_RST[SAC_MODE_LSB +: 2];
            ain_dis_d = SAC_CTRL_ONE_RST[SAC_AIN_DIS_BIT];
            chan_d = SAC_CTRL_ONE_RST[3:0];
            ctl2_d = SAC_CTRL_TWO_RST;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            start_q <= SAC_CTRL_ONE_RST[SAC_START_BIT];
            mode_q <= SAC_CTRL_ONE_RST[SAC_MODE_LSB +: 2];
            ain_dis_q <= SAC_CTRL_ONE_RST[SAC_AIN_DIS_BIT];
            chan_q <= SAC_CTRL_ONE_RST[3:0];
            ctl2_q <= SAC_CTRL_TWO_RST;
        end
        else
        begin
            start_q <= start_d;
            mode_q <= mode_d;
            ain_dis_q <= ain_dis_d;
            chan_q <= chan_d;
            ctl2_q <= ctl2_d;
        end
    end

    // ----------------------------------------
    // Result and status
    // ----------------------------------------
    always_comb
    begin
        res_hi_d = res_hi_q;
        res_lo_d = res_lo_q;
        eoc_d = eoc_q;
        busy_d = busy_q;
        irq_d = 1'b0;
        if (rd_high)
            eoc_d = 1'b0;
        if (go)
            eoc_d = 1'b0;
        if (done || abort)
            busy_d = 1'b0;
        if (go)
            busy_d = 1'b1;
        if (done)
        begin
            // upper eight and lower two bits
            res_hi_d = sar.result[9:2];
            res_lo_d = sar.result[1:0];
            // Set wins over a same-cycle read
            eoc_d = 1'b1;
            irq_d = 1'b1;
        end
        // Standby discards earlier results
        if (standby_i)
        begin
            res_hi_d = SAC_RES_RST;
            res_lo_d = SAC_RES_RST[1:0];
            eoc_d = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            res_hi_q <= SAC_RES_RST;
            res_lo_q <= SAC_RES_RST[1:0];
            eoc_q <= 1'b0;
            busy_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            res_hi_q <= res_hi_d;
            res_lo_q <= res_lo_d;
            eoc_q <= eoc_d;
            busy_q <= busy_d;
            irq_q <= irq_d;
        end
    end

    // ----------------------------------------
    // Read data and analog-side outputs
    // ----------------------------------------
    always_comb
    begin
        rdata_d = 8'h00;
        if (rd_i)
        begin
            case (addr_i)
                SAC_OFS_CTRL_ONE: rdata_d = {start_q, mode_q, ain_dis_q, chan_q};
                SAC_OFS_CTRL_TWO: rdata_d = {2'b00, ctl2_q};
                SAC_OFS_RES_LOW: rdata_d = {res_lo_q, eoc_q, busy_q, 4'h0};
                SAC_OFS_RES_HIGH: rdata_d = res_hi_q;
                default: rdata_d = 8'h00;
            endcase
        end
        dac_d = sar.trial;
        sample_d = sar.sampling;
        ladder_d = ctl2_q[SAC_LADDER_BIT] || sar.busy;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rdata_q <= 8'h00;
            dac_q <= 10'h000;
            sample_q <= 1'b0;
            ladder_q <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            dac_q <= dac_d;
            sample_q <= sample_d;
            ladder_q <= ladder_d;
        end
    end

    assign rdata_o = rdata_q;
    assign dac_code_o = dac_q;
    assign channel_o = chan_q;
    assign sample_o = sample_q;
    assign ladder_on_o = ladder_q;
    assign ain_disable_o = ain_dis_q;
    assign conv_done_irq_o = irq_q;

    sac_sar_core u_core (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .sar(sar.core)
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    start_clear_a: assert property (start_q && !busy_q && mode_q == SAC_MODE_SOFT && !standby_i && !wr_i
        |=> !start_q && busy_q)
        else $error("start bit did not clear");
    mode_gate_a: assert property (go |-> mode_q == SAC_MODE_SOFT || mode_q == SAC_MODE_REPEAT)
        else $error("conversion in disabled mode");
    channel_route_a: assert property (wr_one && !standby_i |=> channel_o == $past(wdata_i[3:0]))
        else $error("channel not routed");
    standby_reset_a: assert property (standby_i |=> {start_q, mode_q, ain_dis_q, chan_q} == SAC_CTRL_ONE_RST
        && ctl2_q == SAC_CTRL_TWO_RST && !busy_q)
        else $error("standby did not reset control");
    ladder_link_a: assert property (ladder_on_o == $past(ctl2_q[SAC_LADDER_BIT] || sar.busy))
        else $error("ladder connection wrong");
    conv_time_a: assert property (go |=> u_core.cnt_q == sac_conv_cycles($past(ctl2_q[3:1])))
        else $error("conversion time not loaded");
    result_store_a: assert property (done |=> {res_hi_q, res_lo_q} == $past(sar.result)
        && eoc_q && conv_done_irq_o)
        else $error("completion not stored");
    read_clear_a: assert property (rd_high && !done |=> !eoc_q)
        else $error("end flag not cleared by read");
    busy_flag_a: assert property (go |=> busy_q ##0 sar.busy)
        else $error("busy flag not set");
    irq_pulse_a: assert property (conv_done_irq_o |=> !conv_done_irq_o)
        else $error("interrupt longer than one cycle");
    repeat_next_a: assert property (done && mode_q == SAC_MODE_REPEAT && !abort |=> busy_q)
        else $error("repeat did not restart");
    halt_drop_a: assert property (abort && !done |=> !busy_q ##1 !conv_done_irq_o
        && $stable(res_hi_q))
        else $error("halt stored partial result");
    keep_result_a: assert property (go && !done |=> !eoc_q && $stable(res_hi_q))
        else $error("restart lost previous result");

    // Cycles since the last start; the longest conversion is too long for a delay range
    logic [10:0] conv_age_q, conv_age_d;

    always_comb
    begin
        conv_age_d = conv_age_q;
        if (go)
            conv_age_d = 11'h000;
        else if (conv_age_q != 11'h7FF)
            conv_age_d = conv_age_q + 11'h001;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            conv_age_q <= 11'h000;
        else
            conv_age_q <= conv_age_d;
    end

    soft_conv_c: cover property (mode_q == SAC_MODE_SOFT && conv_done_irq_o && conv_age_q >= 11'h028);
    repeat_conv_c: cover property (mode_q == SAC_MODE_REPEAT && done ##1 busy_q);
    halt_c: cover property (abort && busy_q);
    standby_c: cover property (standby_i && busy_q);
endmodule

// ==== tb/sac_analog_model.sv ====
// Purpose: Behavioural analog side: sample-hold and comparator
// Assumes: Level of input N is {N, 6'h15}, a code the bench can predict
// Notes: Held level changes only while sampling, like a real hold cap
`timescale 1ns/10ps
module sac_analog_model (
    input wire logic mclk_i,
    input wire logic [3:0] channel_i,
    input wire logic [9:0] dac_code_i,
    input wire logic sample_i,
    output logic cmp_o
);
    logic [9:0] held_q = 10'h000;

    // ----------------------------------------
    // Sample-hold
    // ----------------------------------------
    // routed input sampled
    always @(posedge mclk_i)
    begin
        if (sample_i)
        begin
            held_q <= {channel_i, 6'h15};
        end
    end

    assign cmp_o = (held_q >= dac_code_i);
endmodule

// ==== tb/sac_adc_ctrl_test.sv ====
// Purpose: Self-checking bench for the converter control block
// Assumes: Analog side modelled by sac_analog_model
// Notes: Conversion times are checked with a small slack for pipeline stages
`timescale 1ns/10ps
module sac_adc_ctrl_test;
    import sac_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_n_i;
    logic [7:0] addr_i;
    logic [7:0] wdata_i;
    logic wr_i;
    logic rd_i;
    logic standby_i;
    logic cmp_i;
    logic [7:0] rdata_o;
    logic [9:0] dac_code_o;
    logic [3:0] channel_o;
    logic sample_o;
    logic ladder_on_o;
    logic ain_disable_o;
    logic conv_done_irq_o;
    int num_errors = 0;
    int n_tests = 0;
    int n;
    int tconv [8] = '{39, 39, 78, 156, 312, 624, 1248, 39};
    logic [3:0] chans [3] = '{4'h0, 4'h5, 4'hF};
    logic [9:0] v;

    always #25 mclk_i = ~mclk_i;

    sac_adc_ctrl DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .standby_i(standby_i), .cmp_i(cmp_i), .rdata_o(rdata_o), .dac_code_o(dac_code_o),
        .channel_o(channel_o), .sample_o(sample_o), .ladder_on_o(ladder_on_o), .ain_disable_o(ain_disable_o),
        .conv_done_irq_o(conv_done_irq_o));
    sac_analog_model u_model (.mclk_i(mclk_i), .channel_i(channel_o), .dac_code_i(dac_code_o),
        .sample_i(sample_o), .cmp_o(cmp_i));

    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        // Callers look at outputs only after this edge has updated them
        #1;
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        check(what, {2'b00, exp}, {2'b00, rdata_o});
    endtask

    // Returns lim when no request came; a found request must last one cycle
    task automatic wait_irq(input int lim, output int cnt);
        cnt = 0;
        while (conv_done_irq_o !== 1'b1 && cnt < lim)
        begin
            @(posedge mclk_i);
            #1;
            cnt++;
        end
        if (cnt < lim)
        begin
            @(posedge mclk_i);
            #1;
            check("irq pulse", 10'h000, {9'h000, conv_done_irq_o});
        end
    endtask

    function automatic logic [9:0] lvl(input logic [3:0] c);
        lvl = {c, 6'h15};
    endfunction

    task automatic summarize;
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Tests need under 10000 cycles; four times that cuts a hang short
    initial
    begin
        #(40000 * 50);
        num_errors++;
        summarize;
    end

    initial
    begin
        addr_i = 8'h00;
        wdata_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        standby_i = 1'b0;
        rst_n_i = 1'b0;
        repeat (8) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        // ----------------------------------------
        // Reset values and access kinds
        // ----------------------------------------
        rd_chk("ctrl one", SAC_OFS_CTRL_ONE, SAC_CTRL_ONE_RST);
        rd_chk("ctrl two", SAC_OFS_CTRL_TWO, 8'h00);
        rd_chk("status", SAC_OFS_RES_LOW, 8'h00);
        rd_chk("result high", SAC_OFS_RES_HIGH, SAC_RES_RST);
        rd_chk("unmapped", 8'h20, 8'h00);
        wr(SAC_OFS_RES_HIGH, 8'hFF);
        rd_chk("ro high", SAC_OFS_RES_HIGH, 8'h00);
        check("ain disable", 10'h001, {9'h000, ain_disable_o});
        wr(SAC_OFS_CTRL_TWO, 8'hD0);
        rd_chk("ctrl two top", SAC_OFS_CTRL_TWO, 8'h10);
        check("ladder idle", 10'h000, {9'h000, ladder_on_o});
        // ----------------------------------------
        // Every time code, reserved ones included
        // ----------------------------------------
        v = lvl(4'h3);
        for (int c = 0; c < 8; c++)
        begin
            wr(SAC_OFS_CTRL_TWO, {4'h1, c[2:0], 1'b0});
            wr(SAC_OFS_CTRL_ONE, 8'hA3);
            wait_irq(1400, n);
            check("conv time", 10'h001, {9'h000, (n >= tconv[c] && n <= tconv[c] + 4)});
            rd_chk("high", SAC_OFS_RES_HIGH, v[9:2]);
        end
        // ----------------------------------------
        // Single conversions over channel extremes
        // ----------------------------------------
        wr(SAC_OFS_CTRL_TWO, 8'h18);
        for (int i = 0; i < 3; i++)
        begin
            v = lvl(chans[i]);
            wr(SAC_OFS_CTRL_ONE, {4'hA, chans[i]});
            check("channel", {6'h00, chans[i]}, {6'h00, channel_o});
            check("ain enabled", 10'h000, {9'h000, ain_disable_o});
            repeat (2) @(posedge mclk_i);
            rd_chk("start clears", SAC_OFS_CTRL_ONE, {4'h2, chans[i]});
            rd_chk("busy", SAC_OFS_RES_LOW, {v[1:0], 6'h10});
            check("ladder busy", 10'h001, {9'h000, ladder_on_o});
            wait_irq(400, n);
            check("done", 10'h001, {9'h000, (n < 400)});
            rd_chk("low first", SAC_OFS_RES_LOW, {v[1:0], 6'h20});
            rd_chk("high", SAC_OFS_RES_HIGH, v[9:2]);
            rd_chk("flag cleared", SAC_OFS_RES_LOW, {v[1:0], 6'h00});
        end
        // ----------------------------------------
        // Restart before reading keeps old result
        // ----------------------------------------
        wr(SAC_OFS_CTRL_ONE, 8'hA5);
        wait_irq(400, n);
        wr(SAC_OFS_CTRL_ONE, 8'hA9);
        repeat (3) @(posedge mclk_i);
        v = lvl(4'h5);
        rd_chk("kept low", SAC_OFS_RES_LOW, {v[1:0], 6'h10});
        rd_chk("kept high", SAC_OFS_RES_HIGH, v[9:2]);
        wait_irq(400, n);
        v = lvl(4'h9);
        rd_chk("new high", SAC_OFS_RES_HIGH, v[9:2]);
        // ----------------------------------------
        // Repeat mode, then halt mid-conversion
        // ----------------------------------------
        wr(SAC_OFS_CTRL_TWO, 8'h38);
        @(posedge mclk_i);
        #1;
        check("ladder always", 10'h001, {9'h000, ladder_on_o});
        wr(SAC_OFS_CTRL_ONE, 8'hE7);
        wait_irq(400, n);
        wait_irq(400, n);
        check("second done", 10'h001, {9'h000, (n < 400)});
        v = lvl(4'h7);
        rd_chk("repeat busy", SAC_OFS_RES_LOW, {v[1:0], 6'h30});
        rd_chk("repeat high", SAC_OFS_RES_HIGH, v[9:2]);
        repeat (20) @(posedge mclk_i);
        wr(SAC_OFS_CTRL_ONE, 8'h07);
        repeat (2) @(posedge mclk_i);
        rd_chk("halted", SAC_OFS_RES_LOW, {v[1:0], 6'h00});
        wait_irq(700, n);
        check("no irq", 10'd700, n[9:0]);
        // ----------------------------------------
        // Reserved and disabled modes never start
        // ----------------------------------------
        wr(SAC_OFS_CTRL_ONE, 8'hC7);
        wait_irq(400, n);
        check("mode rsvd", 10'd400, n[9:0]);
        wr(SAC_OFS_CTRL_ONE, 8'h87);
        wait_irq(400, n);
        check("mode off", 10'd400, n[9:0]);
        // ----------------------------------------
        // Standby during conversion
        // ----------------------------------------
        wr(SAC_OFS_CTRL_ONE, 8'hA2);
        repeat (10) @(posedge mclk_i);
        standby_i <= 1'b1;
        wr(SAC_OFS_CTRL_ONE, 8'h25);
        rd_chk("sb ctrl one", SAC_OFS_CTRL_ONE, SAC_CTRL_ONE_RST);
        rd_chk("sb ctrl two", SAC_OFS_CTRL_TWO, 8'h00);
        rd_chk("sb status", SAC_OFS_RES_LOW, 8'h00);
        check("sb ladder", 10'h000, {9'h000, ladder_on_o});
        standby_i <= 1'b0;
        wait_irq(400, n);
        check("sb no irq", 10'd400, n[9:0]);
        wr(SAC_OFS_CTRL_ONE, 8'h13);
        rd_chk("writable", SAC_OFS_CTRL_ONE, 8'h13);
        summarize;
    end
endmodule
